// >>> core/pmwdt_regs.vh
// Summary of operation
// - Writing the unlock value to the control port enters watchdog configuration.
// - Writing the enable value after unlocking turns the watchdog on.
// - Control write of 1 to 4 with a clear upper nibble latches the range multiplier.
// - Base interval in timer port low nibble; the write starts the countdown.
// - Every new interval write restarts the countdown from the full period.
// - Countdown reaching expiry without restart raises system reset or NMI.
// - A static board jumper, not software, picks reset or NMI.
// - Writing zero to the control port disables and stops, in any state.
// - Period is (interval + 1) times step of 0.5, 5, 50 or 100 s.
// - Interval F gives 8, 80, 800 and 1600 s for multipliers 1 to 4.
`ifndef PMWDT_REGS_VH
`define PMWDT_REGS_VH

// I/O port addresses
`define PMWDT_CTRL_PORT 16'h0120
`define PMWDT_INTV_PORT 16'h0121

// Control port command values
`define PMWDT_UNLOCK_VAL 8'h0A
`define PMWDT_ENABLE_VAL 8'h0B
`define PMWDT_DISABLE_VAL 8'h00

// Field positions
`define PMWDT_NIB_LSB 0
`define PMWDT_NIB_MSB 3
`define PMWDT_HI_LSB 4
`define PMWDT_HI_MSB 7

// Reset values
`define PMWDT_MULT_RST 3'h1
`define PMWDT_INTV_RST 4'h0

// Step per multiplier, in 0.5 s ticks
`define PMWDT_STEP_N1 12'h001
`define PMWDT_STEP_N2 12'h00A
`define PMWDT_STEP_N3 12'h064
`define PMWDT_STEP_N4 12'h0C8

// Timing
`define PMWDT_CLK_KHZ 250000
`define PMWDT_TICK_MS 500
`define PMWDT_TICK_CYCLES (`PMWDT_TICK_MS * `PMWDT_CLK_KHZ)
`define PMWDT_RST_HOLD_NS 1000
`define PMWDT_RST_HOLD_CYCLES ((`PMWDT_RST_HOLD_NS * `PMWDT_CLK_KHZ) / 1000000)

`endif

// >>> core/pmwdt_tick.v
`timescale 1ns/100ps
module pmwdt_tick #(
   parameter CNT_W = 27,
   parameter TICK_CYCLES = 125000000
) (
   input wire core_clk_i, // System clock
   input wire sys_rst_i, // Async reset, active high
   input wire run_i, // Divider runs while high
   input wire clr_i, // Restart the tick period
   output reg tick_o // One-cycle pulse per period
);

localparam [31:0] LAST_FULL = TICK_CYCLES - 1;
localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0];

reg [CNT_W-1:0] cnt_q;

// Cleared with the countdown so the first tick is a full period
always @(posedge core_clk_i or posedge sys_rst_i) begin
   if (sys_rst_i) begin
      cnt_q <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
   end else if (clr_i || !run_i) begin
      cnt_q <= {CNT_W{1'b0}};
      tick_o <= 1'b0;
   end else if (cnt_q == LAST) begin
      cnt_q <= {CNT_W{1'b0}};
      tick_o <= 1'b1;
   end else begin
      cnt_q <= cnt_q + 1'b1;
      tick_o <= 1'b0;
   end
end

endmodule

// >>> core/pmwdt_top.v
`timescale 1ns/100ps
`include "pmwdt_regs.vh"
module pmwdt_top #(
   parameter TICK_CYCLES = `PMWDT_TICK_CYCLES,
   parameter TICK_W = 27,
   parameter RST_HOLD = `PMWDT_RST_HOLD_CYCLES,
   parameter HOLD_W = 8
) (
   input wire core_clk_i, // System clock, 250 MHz
   input wire sys_rst_i, // Async reset, active high
   input wire io_wr_i, // I/O write strobe, one cycle
   input wire [15:0] io_addr_i, // I/O port address
   input wire [7:0] io_wdata_i, // I/O write data
   input wire expiry_action_jumper_i, // Board jumper: 1 NMI, 0 reset
   output reg sys_reset_req_o, // Time-out reset request, held
   output reg nmi_req_o, // Time-out NMI, one-cycle pulse
   output reg wd_unlocked_o, // Configuration entered
   output reg wd_enabled_o, // Watchdog enabled
   output reg wd_counting_o, // Countdown running
   output reg wd_expired_o // Time-out seen, sticky
);

localparam [1:0] ST_LOCKED = 2'b00;
localparam [1:0] ST_UNLOCKED = 2'b01;
localparam [1:0] ST_ENABLED = 2'b10;

localparam [31:0] HOLD_LAST_FULL = RST_HOLD - 1;
localparam [HOLD_W-1:0] HOLD_LAST = HOLD_LAST_FULL[HOLD_W-1:0];

reg [1:0] state_q;
reg [1:0] state_d;
reg [2:0] mult_q;
reg [2:0] mult_d;
reg [3:0] intv_q;
reg [3:0] intv_d;
reg [11:0] left_q;
reg [11:0] left_d;
reg counting_d;
reg expired_d;
reg fire_d;
reg jmp_s1_q;
reg jmp_s2_q;
reg [HOLD_W-1:0] hold_q;
reg [11:0] step;
reg [11:0] period;
wire tick;

wire ctrl_wr = io_wr_i && (io_addr_i == `PMWDT_CTRL_PORT);
wire intv_wr = io_wr_i && (io_addr_i == `PMWDT_INTV_PORT);
wire [3:0] wr_nib = io_wdata_i[`PMWDT_NIB_MSB:`PMWDT_NIB_LSB];
wire [3:0] wr_hi = io_wdata_i[`PMWDT_HI_MSB:`PMWDT_HI_LSB];

// Restart is only honoured once the watchdog is enabled
wire restart = intv_wr && (state_q == ST_ENABLED);

// Jumper is a board pin, brought into the clock domain first
always @(posedge core_clk_i or posedge sys_rst_i) begin
   if (sys_rst_i) begin
      jmp_s1_q <= 1'b0;
      jmp_s2_q <= 1'b0;
   end else begin
      jmp_s1_q <= expiry_action_jumper_i;
      jmp_s2_q <= jmp_s1_q;
   end
end

pmwdt_tick #(
   .CNT_W(TICK_W),
   .TICK_CYCLES(TICK_CYCLES)
) u_tick (
   .core_clk_i(core_clk_i),
   .sys_rst_i(sys_rst_i),
   .run_i(wd_counting_o),
   .clr_i(restart),
   .tick_o(tick)
);

// Step length for the written multiplier
always @* begin
   case (mult_q)
      3'h1: step = `PMWDT_STEP_N1;
      3'h2: step = `PMWDT_STEP_N2;
      3'h3: step = `PMWDT_STEP_N3;
      3'h4: step = `PMWDT_STEP_N4;
      default: step = `PMWDT_STEP_N1;
   endcase
end

// Period in ticks: (M + 1) * step, at most 16 * 200 = 3200
always @* begin
   period = step * ({8'h00, wr_nib} + 12'h001);
end

// Configuration state machine and countdown
always @* begin
   state_d = state_q;
   mult_d = mult_q;
   intv_d = intv_q;
   left_d = left_q;
   counting_d = wd_counting_o;
   expired_d = wd_expired_o;
   fire_d = 1'b0;
   case (state_q)
      ST_LOCKED: begin
         if (ctrl_wr && io_wdata_i == `PMWDT_UNLOCK_VAL) begin
            state_d = ST_UNLOCKED;
         end
      end
      ST_UNLOCKED: begin
         if (ctrl_wr && io_wdata_i == `PMWDT_ENABLE_VAL) begin
            state_d = ST_ENABLED;
         end
      end
      ST_ENABLED: begin
         // Only 1 to 4 with a clear upper nibble selects a range
         if (ctrl_wr && wr_hi == 4'h0 && wr_nib >= 4'h1 &&
             wr_nib <= 4'h4) begin
            mult_d = wr_nib[2:0];
         end
         if (restart) begin
            intv_d = wr_nib;
            left_d = period;
            counting_d = 1'b1;
            expired_d = 1'b0;
         end else if (wd_counting_o && tick) begin
            if (left_q == 12'h001) begin
               left_d = 12'h000;
               counting_d = 1'b0;
               expired_d = 1'b1;
               fire_d = 1'b1;
            end else begin
               left_d = left_q - 12'h001;
            end
         end
      end
      default: begin
         state_d = ST_LOCKED;
      end
   endcase
   // Disable wins in any state, including over a time-out in the same cycle
   if (ctrl_wr && io_wdata_i == `PMWDT_DISABLE_VAL) begin
      state_d = ST_LOCKED;
      counting_d = 1'b0;
      left_d = 12'h000;
      expired_d = 1'b0;
      fire_d = 1'b0;
   end
end

always @(posedge core_clk_i or posedge sys_rst_i) begin
   if (sys_rst_i) begin
      state_q <= ST_LOCKED;
      mult_q <= `PMWDT_MULT_RST;
      intv_q <= `PMWDT_INTV_RST;
      left_q <= 12'h000;
      wd_counting_o <= 1'b0;
      wd_expired_o <= 1'b0;
      wd_unlocked_o <= 1'b0;
      wd_enabled_o <= 1'b0;
   end else begin
      state_q <= state_d;
      mult_q <= mult_d;
      intv_q <= intv_d;
      left_q <= left_d;
      wd_counting_o <= counting_d;
      wd_expired_o <= expired_d;
      wd_unlocked_o <= (state_d != ST_LOCKED);
      wd_enabled_o <= (state_d == ST_ENABLED);
   end
end

// Time-out action; reset request is held long enough for the
// board reset logic to see it, NMI is a single edge
always @(posedge core_clk_i or posedge sys_rst_i) begin
   if (sys_rst_i) begin
      sys_reset_req_o <= 1'b0;
      nmi_req_o <= 1'b0;
      hold_q <= {HOLD_W{1'b0}};
   end else begin
      nmi_req_o <= fire_d && jmp_s2_q;
      if (fire_d && !jmp_s2_q) begin
         sys_reset_req_o <= 1'b1;
         hold_q <= {HOLD_W{1'b0}};
      end else if (sys_reset_req_o) begin
         if (hold_q == HOLD_LAST) begin
            sys_reset_req_o <= 1'b0;
         end else begin
            hold_q <= hold_q + 1'b1;
         end
      end
   end
end

endmodule

// >>> verif/pmwdt_monitor.sv
`timescale 1ns/100ps
module pmwdt_monitor (
   input wire core_clk_i, // Clock
   input wire sys_rst_i, // Reset
   input wire io_wr_i, // Strobe
   input wire [15:0] io_addr_i, // Address
   input wire [7:0] io_wdata_i, // Data
   input wire expiry_action_jumper_i, // Jumper
   input wire sys_reset_req_o, // Reset req
   input wire nmi_req_o, // NMI
   input wire wd_unlocked_o, // Unlocked
   input wire wd_enabled_o, // Enabled
   input wire wd_counting_o, // Counting
   input wire wd_expired_o // Expired
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire cw = io_wr_i && io_addr_i == 16'h0120;
   wire iw = io_wr_i && io_addr_i == 16'h0121;
   AST_UNLOCK: assert property (cw && io_wdata_i == 8'h0A &&
      !wd_unlocked_o |=> wd_unlocked_o) else $error("unlock missed");
   AST_ENABLE: assert property (cw && io_wdata_i == 8'h0B &&
      wd_unlocked_o |=> wd_enabled_o) else $error("enable missed");
   AST_START: assert property (iw && wd_enabled_o |=>
      wd_counting_o && !wd_expired_o) else $error("no start");
   AST_IGNORE: assert property (iw && !wd_enabled_o |=>
      !wd_counting_o) else $error("locked write took effect");
   AST_OFF: assert property (cw && io_wdata_i == 8'h00 |=>
      !(wd_unlocked_o | wd_enabled_o | wd_counting_o | wd_expired_o))
      else $error("disable missed");
   AST_STOP: assert property ($rose(wd_expired_o) |->
      $past(wd_counting_o) && !wd_counting_o) else $error("bad expiry");
   AST_NMI: assert property ($rose(wd_expired_o) &&
      expiry_action_jumper_i |-> nmi_req_o ##1 !nmi_req_o)
      else $error("nmi pulse wrong");
   AST_RST: assert property ($rose(wd_expired_o) &&
      !expiry_action_jumper_i |-> (sys_reset_req_o && !nmi_req_o) [*4])
      else $error("reset request wrong");
endmodule

// >>> verif/tb.sv
`timescale 1ns/100ps
`include "pmwdt_regs.vh"
module tb;
   reg core_clk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg io_wr_i = 1'b0;
   reg [15:0] io_addr_i = 16'h0000;
   reg [7:0] io_wdata_i = 8'h00;
   reg expiry_action_jumper_i = 1'b1;
   wire sys_reset_req_o, nmi_req_o, wd_unlocked_o;
   wire wd_enabled_o, wd_counting_o, wd_expired_o;
   integer errors = 0;
   integer samples_checked = 0;
   integer c, e, n, m;
   localparam TC = 4;
   pmwdt_top #(.TICK_CYCLES(TC), .TICK_W(27), .RST_HOLD(4), .HOLD_W(8))
      i_dut (
         .core_clk_i(core_clk_i),
         .sys_rst_i(sys_rst_i),
         .io_wr_i(io_wr_i),
         .io_addr_i(io_addr_i),
         .io_wdata_i(io_wdata_i),
         .expiry_action_jumper_i(expiry_action_jumper_i),
         .sys_reset_req_o(sys_reset_req_o),
         .nmi_req_o(nmi_req_o),
         .wd_unlocked_o(wd_unlocked_o),
         .wd_enabled_o(wd_enabled_o),
         .wd_counting_o(wd_counting_o),
         .wd_expired_o(wd_expired_o)
      );
   always #2 core_clk_i = ~core_clk_i;
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      samples_checked = samples_checked + 1;
      if (g !== ex) begin
         errors = errors + 1;
         $display("wrong value %s exp %0h got %0h", nm, ex, g);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      io_addr_i <= a;
      io_wdata_i <= d;
      io_wr_i <= 1'b1;
      @(posedge core_clk_i);
      io_wr_i <= 1'b0;
   endtask
   task arm(input logic [7:0] nn, input logic [7:0] mm);
      wr(`PMWDT_CTRL_PORT, 8'h00);
      wr(`PMWDT_CTRL_PORT, 8'h0A);
      wr(`PMWDT_CTRL_PORT, 8'h0B);
      wr(`PMWDT_CTRL_PORT, nn);
      wr(`PMWDT_INTV_PORT, mm);
   endtask
   task wait_exp;
      c = 0;
      while (wd_expired_o !== 1'b1 && c < 14000) begin
         @(posedge core_clk_i);
         #1;
         c = c + 1;
      end
   endtask
   task t_locked;
      wr(`PMWDT_INTV_PORT, 8'h05);
      #1 chk("counting", 0, wd_counting_o);
      wr(`PMWDT_CTRL_PORT, 8'h0B);
      #1 chk("enabled", 0, wd_enabled_o);
      wr(16'h0122, 8'h0A);
      #1 chk("unlocked", 0, wd_unlocked_o);
   endtask
   task t_period(input integer tk);
      expiry_action_jumper_i <= n[0];
      arm(n[7:0], m[7:0]);
      wait_exp;
      e = tk * TC + 2;
      chk("period", 1, c >= e - 2 && c <= e + 2);
      chk("nmi", n[0], nmi_req_o);
      chk("sysrst", !n[0], sys_reset_req_o);
      @(posedge core_clk_i);
      #1 chk("nmi_end", 0, nmi_req_o);
   endtask
   task t_restart;
      arm(8'h01, 8'h03);
      repeat (3) begin
         repeat (10) @(posedge core_clk_i);
         wr(`PMWDT_INTV_PORT, 8'h03);
      end
      #1 chk("early", 0, wd_expired_o);
      wait_exp;
      chk("restart", 1, c >= 16 && c <= 20);
   endtask
   task t_disable;
      arm(8'h02, 8'h00);
      repeat (20) @(posedge core_clk_i);
      wr(`PMWDT_CTRL_PORT, 8'h00);
      @(posedge core_clk_i);
      #1 chk("stopped", 0, wd_counting_o | wd_enabled_o);
      repeat (60) @(posedge core_clk_i);
      chk("expired", 0, wd_expired_o);
   endtask
   task print_verdict;
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #200000;
      errors = errors + 1;
      print_verdict;
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_locked;
      for (n = 1; n <= 4; n = n + 1) begin
         m = 15;
         t_period(16 * (n == 1 ? 1 : n == 2 ? 10 : n == 3 ? 100 : 200));
         m = 0;
         t_period(n == 1 ? 1 : n == 2 ? 10 : n == 3 ? 100 : 200);
      end
      t_restart;
      t_disable;
      print_verdict;
   end
endmodule
bind pmwdt_top pmwdt_monitor i_mon (.*);
